// [ahb_master_model.sv]
// Single-transfer AHB-Lite master that stands in for the host side
`timescale 1ns/1ns
module ahb_master_model (
   input  wire logic        mclk_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   output logic             hsel_out,
   output logic      [31:0] haddr_out,
   output logic      [1:0]  htrans_out,
   output logic             hwrite_out,
   output logic      [2:0]  hsize_out,
   output logic      [31:0] hwdata_out
);
   import wiper_pkg::*;
   logic        rdy_s;
   logic [31:0] rd_s;
   initial begin
      hsel_out   = 1'h0;
      haddr_out  = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'h0;
      hsize_out  = 3'h2;
      hwdata_out = 32'h0;
   end
   // Inputs only move at rising edges, so the late half-cycle value is what the next edge sees
   always @(negedge mclk_in) begin
      rdy_s = hready_in;
      rd_s  = hrdata_in;
   end
   // One word carries the command byte and its data byte together
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge mclk_in);
      hsel_out   <= 1'h1;
      htrans_out <= HTRANS_NONSEQ;
      haddr_out  <= {24'h0, a};
      hwrite_out <= wr;
      do @(posedge mclk_in); while (rdy_s !== 1'h1);
      hsel_out   <= 1'h0;
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      do @(posedge mclk_in); while (rdy_s !== 1'h1);
      rd = rd_s;
      // Stale write data is inverted so nothing can lean on a held value
      hwdata_out <= ~wd;
   endtask
endmodule

// [tap_select.sv]
// Tap position mux between stored register and forced scale points
`timescale 1ns/1ns
module tap_select (
   input  wire logic [7:0] wiper_in,
   input  wire logic [1:0] sel_in,
   output logic      [7:0] tap_out
);
   import wiper_pkg::*;
   always_comb begin
      unique case (sel_in)
         SEL_ZERO: tap_out = TAP_ZERO;
         SEL_MID:  tap_out = TAP_MID;
         SEL_FULL: tap_out = TAP_FULL;
         default:  tap_out = wiper_in;
      endcase
   end
endmodule

// [wiper_pkg.sv]
// Package with register map, command codes and reset values for the wiper decoder
package wiper_pkg;
   localparam logic [7:0]  WIPER_RESET         = 8'h80;
   localparam logic [7:0]  TAP_ZERO            = 8'h00;
   localparam logic [7:0]  TAP_MID             = 8'h80;
   localparam logic [7:0]  TAP_FULL            = 8'hFF;
   localparam logic        PUMP_RESET          = 1'b1;
   localparam logic [7:0]  CMD_WIPER_WRITE     = 8'h00;
   localparam logic [7:0]  CMD_SHUTDOWN_CLEAR  = 8'h80;
   localparam logic [7:0]  CMD_HIGH_OPEN_BASE  = 8'h90;
   localparam logic [7:0]  CMD_LOW_OPEN_BASE   = 8'h88;
   localparam logic [7:0]  CMD_WIPER_OPEN      = 8'h84;
   localparam logic [7:0]  CMD_PUMP_DISABLE    = 8'hA0;
   localparam logic [7:0]  CMD_PUMP_ENABLE     = 8'hA1;
   localparam logic [7:0]  CMD_RESET           = 8'hC0;
   localparam logic [7:0]  GENERAL_CALL_RESET  = 8'h06;
   localparam logic [1:0]  SEL_REGISTER        = 2'b00;
   localparam logic [1:0]  SEL_ZERO            = 2'b01;
   localparam logic [1:0]  SEL_MID             = 2'b10;
   localparam logic [1:0]  SEL_FULL            = 2'b11;
   // AHB register byte addresses
   localparam logic [7:0]  ADDR_CMD            = 8'h00;
   localparam logic [7:0]  ADDR_GCALL          = 8'h04;
   localparam logic [7:0]  ADDR_WIPER          = 8'h08;
   localparam logic [7:0]  ADDR_CONFIG         = 8'h0C;
   localparam logic [7:0]  ADDR_TAP            = 8'h10;
   // Config field positions
   localparam int          CFG_PUMP_BIT        = 7;
   localparam int          CFG_HIGH_BIT        = 4;
   localparam int          CFG_LOW_BIT         = 3;
   localparam int          CFG_WIPER_BIT       = 2;
   localparam logic [1:0]  HTRANS_NONSEQ       = 2'b10;
   localparam logic [31:0] CMD_DATA_SHIFT_POS  = 32'd8;
endpackage

// [wiper_shutdown_command_decoder.sv]
// Command decoder for a 256-position wiper with shutdown and pump control
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
// Contract
// - Wiper write stores data byte and moves tap at once.
// - Code 0x00 is nearest L, 0xFF nearest H, linear between.
// - Power-on sets wiper register and tap to 0x80.
// - Shutdown clear closes all terminals, tap returns to register.
// - Shutdown clear leaves pump enable unchanged.
// - High-open keep opens H, tap follows register.
// - High-open zero/mid/full opens H, forces tap, register kept.
// - Low-open keep opens L, tap follows register.
// - Low-open zero/mid/full opens L, forces tap, register kept.
// - Wiper-open opens W, tap follows register.
// - Wiper writes ignored while any shutdown is engaged.
// - Clearing shutdown closes terminal, restores tap, re-enables writes.
// - Reset during shutdown ends it and sets tap and register to 0x80.
// - Shutdown commands never change pump enable.
// - Pump-off disables the charge pump, low-power mode.
// - Pump-on enables the pump; enabled is the power-on default.
// - Reset command restores all power-on defaults.
// - Config status shows pump, switch opens and two-bit tap select.
// - General call data 0x06 acts as the reset command.
module wiper_shutdown_command_decoder (
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic      [7:0]  tap_position_out,
   output logic             pump_enabled_flag_out,
   output logic             high_switch_open_flag_out,
   output logic             low_switch_open_flag_out,
   output logic             wiper_switch_open_flag_out
);
   import wiper_pkg::*;

   logic [7:0] wiper_reg;
   logic       pump_enabled_flag;
   logic       high_switch_open_flag;
   logic       low_switch_open_flag;
   logic       wiper_switch_open_flag;
   logic [1:0] tap_source_select;
   logic [7:0] next_tap;
   logic       dphase_write;
   logic       dphase_read;
   logic [7:0] dphase_addr;
   logic       cmd_valid;
   logic [7:0] cmd_byte;
   logic [7:0] data_byte;
   logic       gcall_valid;
   logic       shutdown_active;
   logic       soft_reset;
   logic       read_taken;
   logic [31:0] next_rdata;

   // A command word carries the command byte in [15:8] and the data byte in [7:0],
   // standing in for the command and data bytes of a serial frame
   function automatic logic is_high_open(input logic [7:0] c);
      return c[7:2] == CMD_HIGH_OPEN_BASE[7:2];
   endfunction
   function automatic logic is_low_open(input logic [7:0] c);
      return c[7:2] == CMD_LOW_OPEN_BASE[7:2];
   endfunction
   // Unknown codes change nothing; the data byte only matters to a wiper write
   function automatic logic is_known_cmd(input logic [7:0] c);
      return c == CMD_WIPER_WRITE || c == CMD_SHUTDOWN_CLEAR || is_high_open(c)
             || is_low_open(c) || c == CMD_WIPER_OPEN || c == CMD_PUMP_DISABLE
             || c == CMD_PUMP_ENABLE || c == CMD_RESET;
   endfunction

   // Address phase capture; held while a read waits, since hready is low then
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         dphase_write <= 1'b0;
         dphase_read  <= 1'b0;
         dphase_addr  <= 8'h00;
      end else if (hready_in) begin
         dphase_write <= hsel_in && htrans_in[1] && hwrite_in;
         dphase_read  <= hsel_in && htrans_in[1] && !hwrite_in;
         dphase_addr  <= haddr_in[7:0];
      end
   end

   // Reads insert one wait state so read data comes from a flop and still sees
   // a write that landed on the edge before; writes never wait
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         hreadyout_out <= 1'b1;
      end else if (read_taken) begin
         hreadyout_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
      end
   end

   // Every transfer is answered OKAY
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         hresp_out <= 1'b0;
      end else begin
         hresp_out <= 1'b0;
      end
   end

   always_comb begin
      cmd_valid   = dphase_write && (dphase_addr == ADDR_CMD);
      gcall_valid = dphase_write && (dphase_addr == ADDR_GCALL)
                    && (hwdata_in[7:0] == GENERAL_CALL_RESET);
      cmd_byte    = hwdata_in[15:8];
      data_byte   = hwdata_in[7:0];
      read_taken  = hready_in && hsel_in && htrans_in[1] && !hwrite_in;
   end

   assign shutdown_active = high_switch_open_flag || low_switch_open_flag
                            || wiper_switch_open_flag || (tap_source_select != SEL_REGISTER);
   // Reset command and general call share one path
   assign soft_reset = (cmd_valid && cmd_byte == CMD_RESET) || gcall_valid;

   // Wiper register
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wiper_reg <= WIPER_RESET;
      end else if (soft_reset) begin
         wiper_reg <= WIPER_RESET;
      end else if (cmd_valid && cmd_byte == CMD_WIPER_WRITE && !shutdown_active) begin
         wiper_reg <= data_byte;
      end
   end

   // Charge pump enable; shutdown commands leave it alone
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pump_enabled_flag <= PUMP_RESET;
      end else if (soft_reset) begin
         pump_enabled_flag <= PUMP_RESET;
      end else if (cmd_valid && cmd_byte == CMD_PUMP_DISABLE) begin
         pump_enabled_flag <= 1'b0;
      end else if (cmd_valid && cmd_byte == CMD_PUMP_ENABLE) begin
         pump_enabled_flag <= 1'b1;
      end
   end

   // Shutdown state: which switch is open and which tap source drives
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || soft_reset) begin
         high_switch_open_flag  <= 1'b0;
         low_switch_open_flag   <= 1'b0;
         wiper_switch_open_flag <= 1'b0;
         tap_source_select      <= SEL_REGISTER;
      end else if (cmd_valid) begin
         if (cmd_byte == CMD_SHUTDOWN_CLEAR) begin
            high_switch_open_flag  <= 1'b0;
            low_switch_open_flag   <= 1'b0;
            wiper_switch_open_flag <= 1'b0;
            tap_source_select      <= SEL_REGISTER;
         end else if (is_high_open(cmd_byte)) begin
            high_switch_open_flag  <= 1'b1;
            low_switch_open_flag   <= 1'b0;
            wiper_switch_open_flag <= 1'b0;
            tap_source_select      <= cmd_byte[1:0];
         end else if (is_low_open(cmd_byte)) begin
            high_switch_open_flag  <= 1'b0;
            low_switch_open_flag   <= 1'b1;
            wiper_switch_open_flag <= 1'b0;
            tap_source_select      <= cmd_byte[1:0];
         end else if (cmd_byte == CMD_WIPER_OPEN) begin
            high_switch_open_flag  <= 1'b0;
            low_switch_open_flag   <= 1'b0;
            wiper_switch_open_flag <= 1'b1;
            tap_source_select      <= SEL_REGISTER;
         end
      end
   end

   // Tap is muxed from state in the same cycle and registered at the output, so it lags the register by one edge
   tap_select u_tap_select (
      .wiper_in (wiper_reg),
      .sel_in   (tap_source_select),
      .tap_out  (next_tap)
   );

   // Registered outputs; code maps linearly from L (0x00) to H (0xFF)
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tap_position_out           <= WIPER_RESET;
         pump_enabled_flag_out      <= PUMP_RESET;
         high_switch_open_flag_out  <= 1'b0;
         low_switch_open_flag_out   <= 1'b0;
         wiper_switch_open_flag_out <= 1'b0;
      end else begin
         tap_position_out           <= next_tap;
         pump_enabled_flag_out      <= pump_enabled_flag;
         high_switch_open_flag_out  <= high_switch_open_flag;
         low_switch_open_flag_out   <= low_switch_open_flag;
         wiper_switch_open_flag_out <= wiper_switch_open_flag;
      end
   end

   // Read word; unmapped reads return zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (dphase_addr)
         ADDR_WIPER: next_rdata[7:0] = wiper_reg;
         ADDR_CONFIG: begin
            next_rdata[CFG_PUMP_BIT]  = pump_enabled_flag;
            next_rdata[CFG_HIGH_BIT]  = high_switch_open_flag;
            next_rdata[CFG_LOW_BIT]   = low_switch_open_flag;
            next_rdata[CFG_WIPER_BIT] = wiper_switch_open_flag;
            next_rdata[1:0]           = tap_source_select;
         end
         ADDR_TAP: next_rdata[7:0] = tap_position_out;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data stands only through the last cycle of the read data phase
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (dphase_read && !hreadyout_out) begin
         hrdata_out <= next_rdata;
      end else begin
         hrdata_out <= 32'h0000_0000;
      end
   end

   // Bus answer: OKAY always, one wait state on every read
   a_resp_okay: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      !hresp_out)
      else $error("error response on bus");
   a_read_wait: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      read_taken |=> !hreadyout_out ##1 hreadyout_out && hrdata_out == $past(next_rdata))
      else $error("read data phase wrong");
   a_read_idle: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      hreadyout_out |=> hrdata_out == 32'h0000_0000)
      else $error("read data outside data phase");

   // Reset and status path
   a_power_defaults: assert property (@(posedge mclk_in)
      !resetn_in |=> wiper_reg == WIPER_RESET && pump_enabled_flag == PUMP_RESET
      && tap_position_out == WIPER_RESET && !shutdown_active)
      else $error("power-on defaults wrong");
   a_reset_defaults: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      soft_reset |=> wiper_reg == TAP_MID && pump_enabled_flag && !shutdown_active
      ##1 tap_position_out == TAP_MID)
      else $error("reset did not restore defaults");
   a_reset_shutdown: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && cmd_byte == CMD_RESET && shutdown_active
      |=> !shutdown_active && wiper_reg == WIPER_RESET)
      else $error("reset left shutdown engaged");
   a_gcall_reset: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      gcall_valid |=> wiper_reg == WIPER_RESET && pump_enabled_flag && !shutdown_active)
      else $error("general call reset failed");
   a_status_follow: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      1'b1 |=> pump_enabled_flag_out == $past(pump_enabled_flag)
      && high_switch_open_flag_out == $past(high_switch_open_flag)
      && low_switch_open_flag_out == $past(low_switch_open_flag)
      && wiper_switch_open_flag_out == $past(wiper_switch_open_flag))
      else $error("status outputs do not follow state");
   a_tap_linear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      tap_source_select == SEL_REGISTER |=> tap_position_out == $past(wiper_reg))
      else $error("tap does not follow wiper code");

   // Wiper writes and unknown commands
   a_write_blocked: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && cmd_byte == CMD_WIPER_WRITE && shutdown_active
      |=> $stable(wiper_reg))
      else $error("wiper register changed during shutdown");
   a_write_stores: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && cmd_byte == CMD_WIPER_WRITE && !shutdown_active && !soft_reset
      |=> wiper_reg == $past(data_byte) ##1 tap_position_out == $past(data_byte, 2))
      else $error("wiper write did not reach tap");
   a_unknown_ignored: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !is_known_cmd(cmd_byte)
      |=> $stable({wiper_reg, pump_enabled_flag, tap_source_select,
                   high_switch_open_flag, low_switch_open_flag, wiper_switch_open_flag}))
      else $error("unknown command changed state");

   // Shutdown modes
   a_high_keep: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_HIGH_OPEN_BASE
      |=> high_switch_open_flag ##1 tap_position_out == wiper_reg)
      else $error("high open keep tap wrong");
   a_high_mid: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == (CMD_HIGH_OPEN_BASE | 8'h02)
      |=> ##1 tap_position_out == TAP_MID && high_switch_open_flag_out)
      else $error("high open mid tap wrong");
   a_high_forced: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && is_high_open(cmd_byte)
      |=> high_switch_open_flag && $stable(wiper_reg))
      else $error("high open failed");
   a_low_keep: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_LOW_OPEN_BASE
      |=> low_switch_open_flag ##1 tap_position_out == wiper_reg)
      else $error("low open keep tap wrong");
   a_low_zero: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == (CMD_LOW_OPEN_BASE | 8'h01)
      |=> ##1 tap_position_out == TAP_ZERO && low_switch_open_flag_out)
      else $error("low open zero tap wrong");
   a_low_full: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == (CMD_LOW_OPEN_BASE | 8'h03)
      |=> ##1 tap_position_out == TAP_FULL && low_switch_open_flag_out)
      else $error("low open full tap wrong");
   a_wiper_open: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_WIPER_OPEN
      |=> wiper_switch_open_flag ##1 tap_position_out == wiper_reg)
      else $error("wiper open wrong");
   a_clear_switches: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_SHUTDOWN_CLEAR
      |=> !shutdown_active)
      else $error("clear left a switch open");
   a_clear_restores: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_SHUTDOWN_CLEAR
      |=> ##1 tap_position_out == wiper_reg && !high_switch_open_flag_out)
      else $error("clear did not restore tap");
   a_clear_pump: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && cmd_byte == CMD_SHUTDOWN_CLEAR |=> $stable(pump_enabled_flag))
      else $error("clear changed pump state");
   a_pump_kept: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && (cmd_byte == CMD_SHUTDOWN_CLEAR || is_high_open(cmd_byte)
      || is_low_open(cmd_byte) || cmd_byte == CMD_WIPER_OPEN)
      |=> $stable(pump_enabled_flag))
      else $error("shutdown changed pump state");

   // Charge pump
   a_pump_off: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_PUMP_DISABLE
      |=> !pump_enabled_flag ##1 !pump_enabled_flag_out)
      else $error("pump not disabled");
   a_pump_on: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      cmd_valid && !soft_reset && cmd_byte == CMD_PUMP_ENABLE
      |=> pump_enabled_flag ##1 pump_enabled_flag_out)
      else $error("pump not enabled");

   c_wiper_write: cover property (@(posedge mclk_in)
      cmd_valid && cmd_byte == CMD_WIPER_WRITE && !shutdown_active);
   c_blocked_write: cover property (@(posedge mclk_in)
      cmd_valid && cmd_byte == CMD_WIPER_WRITE && shutdown_active);
   c_gcall_reset: cover property (@(posedge mclk_in) gcall_valid && shutdown_active);
   c_pump_off: cover property (@(posedge mclk_in) cmd_valid && cmd_byte == CMD_PUMP_DISABLE);
   c_low_forced: cover property (@(posedge mclk_in)
      cmd_valid && is_low_open(cmd_byte) && cmd_byte[1:0] != SEL_REGISTER);
endmodule

// [wiper_shutdown_command_decoder_tb_top.sv]
// Self-checking bench for the wiper shutdown command decoder
`timescale 1ns/1ns
module wiper_shutdown_command_decoder_tb_top;
   import wiper_pkg::*;
   logic        mclk_in;
   logic        resetn_in;
   logic        hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  tap;
   logic        pump, hopen, lopen, wopen;
   int          err_total;
   int          tests_run;
   wiper_shutdown_command_decoder i_wiper_shutdown_command_decoder (
      .mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .tap_position_out(tap), .pump_enabled_flag_out(pump),
      .high_switch_open_flag_out(hopen), .low_switch_open_flag_out(lopen),
      .wiper_switch_open_flag_out(wopen));
   ahb_master_model i_ahb_master_model (
      .mclk_in(mclk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata));
   initial begin
      mclk_in = 1'h0;
      forever #20 mclk_in = ~mclk_in;
   end
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      i_ahb_master_model.xfer(1'h1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      i_ahb_master_model.xfer(1'h0, a, 32'h0, r);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      wr(ADDR_CMD, {16'h0000, c, d});
   endtask
   // Outputs land one edge after the state, so look in the following low half
   task automatic status(input logic [7:0] t, input logic [7:0] cfg);
      logic [31:0] r;
      @(posedge mclk_in);
      @(negedge mclk_in);
      check({24'h0, tap}, {24'h0, t});
      check({24'h0, pump, 2'h0, hopen, lopen, wopen, 2'h0}, {24'h0, cfg[7:2], 2'h0});
      check({31'h0, hresp}, 32'h0);
      rd(ADDR_CONFIG, r);
      check(r, {24'h0, cfg});
      rd(ADDR_TAP, r);
      check(r, {24'h0, t});
   endtask
   task automatic wiper_is(input logic [7:0] w);
      logic [31:0] r;
      rd(ADDR_WIPER, r);
      check(r, {24'h0, w});
   endtask
   initial begin
      logic [7:0] w, c, t;
      logic [1:0] sel;
      logic [2:0] fl;
      logic       p;
      logic [31:0] r;
      resetn_in = 1'h0;
      err_total = 0;
      tests_run = 0;
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'h1;
      status(TAP_MID, 8'h80);
      wiper_is(WIPER_RESET);
      $display("Test reset defaults done");
      for (int i = 0; i < 9; i++) begin
         w   = 8'h30 + 8'(i);
         p   = ~i[0];
         sel = (i < 8) ? 2'(i % 4) : SEL_REGISTER;
         fl  = (i < 4) ? 3'h4 : (i < 8) ? 3'h2 : 3'h1;
         c   = (i < 4) ? CMD_HIGH_OPEN_BASE + 8'(i) :
               (i < 8) ? CMD_LOW_OPEN_BASE + 8'(i - 4) : CMD_WIPER_OPEN;
         t   = (sel == SEL_ZERO) ? TAP_ZERO : (sel == SEL_MID) ? TAP_MID :
               (sel == SEL_FULL) ? TAP_FULL : w;
         cmd(CMD_WIPER_WRITE, w);
         cmd(p ? CMD_PUMP_ENABLE : CMD_PUMP_DISABLE, 8'h5A);
         status(w, {p, 7'h00});
         cmd(c, 8'hA5);
         status(t, {p, 2'h0, fl, sel});
         cmd(CMD_WIPER_WRITE, 8'h11);
         wiper_is(w);
         status(t, {p, 2'h0, fl, sel});
         cmd(CMD_SHUTDOWN_CLEAR, 8'hFF);
         status(w, {p, 7'h00});
      end
      cmd(CMD_WIPER_WRITE, 8'h99);
      status(8'h99, 8'h80);
      $display("Test shutdown modes done");
      cmd(CMD_WIPER_WRITE, TAP_ZERO);
      status(TAP_ZERO, 8'h80);
      cmd(CMD_WIPER_WRITE, TAP_FULL);
      status(TAP_FULL, 8'h80);
      cmd(8'hC5, 8'h12);
      status(TAP_FULL, 8'h80);
      $display("Test scale ends done");
      cmd(CMD_WIPER_WRITE, 8'h22);
      cmd(CMD_HIGH_OPEN_BASE + 8'h2, 8'h00);
      cmd(CMD_RESET, 8'h3C);
      status(TAP_MID, 8'h80);
      wiper_is(WIPER_RESET);
      $display("Test reset command done");
      cmd(CMD_WIPER_WRITE, 8'h44);
      cmd(CMD_PUMP_DISABLE, 8'h00);
      cmd(CMD_LOW_OPEN_BASE + 8'h3, 8'h00);
      wr(ADDR_GCALL, 32'h0000_0005);
      wr(8'h20, 32'h0000_A100);
      rd(8'h20, r);
      check(r, 32'h0);
      status(TAP_FULL, 8'h0B);
      wr(ADDR_GCALL, {24'h0, GENERAL_CALL_RESET});
      status(TAP_MID, 8'h80);
      wiper_is(WIPER_RESET);
      $display("Test general call done");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      err_total++;
      final_report();
   end
endmodule
